/* adg_pkg.sv */
package adg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned REFRESH_MS  = 200;
  localparam int unsigned CLK_KHZ     = 100000;
  localparam int unsigned REFRESH_CYC = REFRESH_MS * CLK_KHZ;

  // ----------------------------------------------------------------
  // Loop current limits, in microamps
  // ----------------------------------------------------------------
  localparam logic [15:0] CUR_LO_UA = 16'h0dac;  // 3500 uA
  localparam logic [15:0] CUR_HI_UA = 16'h5014;  // 20500 uA

  // ----------------------------------------------------------------
  // Status word layout
  // ----------------------------------------------------------------
  localparam int unsigned SB_CFG_OK   = 0;
  localparam int unsigned SB_S1_LO_IN = 1;
  localparam int unsigned SB_S1_HI_IN = 2;
  localparam int unsigned SB_S2_LO_IN = 3;
  localparam int unsigned SB_S2_HI_IN = 4;
  localparam int unsigned SB_S1_LO_PR = 5;
  localparam int unsigned SB_S1_HI_PR = 6;
  localparam int unsigned SB_S2_LO_PR = 7;
  localparam int unsigned SB_S2_HI_PR = 8;
  localparam int unsigned SB_DISC_OK  = 9;
  localparam int unsigned SB_CN_LO_PR = 10;
  localparam int unsigned SB_CN_HI_PR = 11;
  localparam int unsigned SB_IN_DATA  = 12;
  localparam int unsigned SB_MV_LSB   = 16;
  localparam int unsigned SB_MV_MSB   = 31;
  localparam logic [31:0] STATUS_RST  = 32'h0000_0000;
  localparam logic [15:0] MV_HIDDEN   = 16'hffff;

  // ----------------------------------------------------------------
  // Recorder
  // ----------------------------------------------------------------
  localparam int unsigned REC_CHANS  = 4;
  localparam int unsigned REC_BITS   = 45;
  localparam logic [5:0]  REC_OFF    = 6'h00;
  localparam logic [5:0]  REC_ANALOG = 6'h01;
  localparam logic [5:0]  REC_BIT0   = 6'h02;

  typedef enum logic [2:0] {
    ADG_SRC_S1_FILT,
    ADG_SRC_S2_FILT,
    ADG_SRC_S1_DELAY,
    ADG_SRC_CONS,
    ADG_SRC_S1_RAW,
    ADG_SRC_S2_RAW
  } adg_src_e;

endpackage

/* adg_meas_if.sv */
interface adg_meas_if;
  import adg_pkg::*;

  logic [15:0] cur_ua   [2];
  logic [15:0] filt     [2];
  logic [15:0] raw      [2];
  logic [15:0] s1_delay;
  logic [15:0] cons_val;
  logic [15:0] proc_min;
  logic [15:0] proc_max;
  logic [1:0]  lo_in_ok;
  logic [1:0]  hi_in_ok;
  logic [1:0]  lo_pr_ok;
  logic [1:0]  hi_pr_ok;
  logic        cn_lo_ok;
  logic        cn_hi_ok;

  modport top (
    output cur_ua, filt, raw, s1_delay, cons_val, proc_min, proc_max,
    input  lo_in_ok, hi_in_ok, lo_pr_ok, hi_pr_ok, cn_lo_ok, cn_hi_ok
  );
  modport chk (
    input  cur_ua, filt, cons_val, proc_min, proc_max,
    output lo_in_ok, hi_in_ok, lo_pr_ok, hi_pr_ok, cn_lo_ok, cn_hi_ok
  );
  modport rec (
    input  filt, raw, s1_delay, cons_val
  );
endinterface

/* adg_range_chk.sv */
module adg_range_chk
  import adg_pkg::*;
(
  adg_meas_if.chk m
);

  // ----------------------------------------------------------------
  // Comparisons
  // ----------------------------------------------------------------
  // Ok unless strictly past the bound; equal counts as inside
  function automatic logic not_below(input logic [15:0] v, input logic [15:0] lim);
    not_below = (v >= lim);
  endfunction

  function automatic logic not_above(input logic [15:0] v, input logic [15:0] lim);
    not_above = (v <= lim);
  endfunction

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_sens
      assign m.lo_in_ok[g] = not_below(m.cur_ua[g], CUR_LO_UA);  // RULE_02
      assign m.hi_in_ok[g] = not_above(m.cur_ua[g], CUR_HI_UA);  // RULE_03
      assign m.lo_pr_ok[g] = not_below(m.filt[g], m.proc_min);   // RULE_04
      assign m.hi_pr_ok[g] = not_above(m.filt[g], m.proc_max);   // RULE_05
    end
  endgenerate

  assign m.cn_lo_ok = not_below(m.cons_val, m.proc_min);  // RULE_07
  assign m.cn_hi_ok = not_above(m.cons_val, m.proc_max);  // RULE_07

endmodule

/* adg_rec_sel.sv */
module adg_rec_sel
  import adg_pkg::*;
(
  adg_meas_if.rec                m,
  input  wire adg_src_e          ana_src,
  input  wire logic [5:0]        chan_sel [REC_CHANS],
  input  wire logic [REC_BITS-1:0] bit_pool,
  output logic [15:0]            ana_val,
  output logic [REC_CHANS-1:0]   chan_bit,
  output logic [REC_CHANS-1:0]   chan_act
);

  // ----------------------------------------------------------------
  // Analog source pick
  // ----------------------------------------------------------------
  always_comb
  begin
    case (ana_src)  // RULE_12
      ADG_SRC_S1_FILT:  ana_val = m.filt[0];
      ADG_SRC_S2_FILT:  ana_val = m.filt[1];
      ADG_SRC_S1_DELAY: ana_val = m.s1_delay;
      ADG_SRC_CONS:     ana_val = m.cons_val;
      ADG_SRC_S1_RAW:   ana_val = m.raw[0];
      ADG_SRC_S2_RAW:   ana_val = m.raw[1];
      default:          ana_val = m.cons_val;
    endcase
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  // Only one analog channel per module; later claims are dropped
  always_comb
  begin
    logic ana_taken;
    logic [5:0] idx;
    ana_taken = 1'b0;
    idx       = 6'h00;
    chan_bit  = '0;
    chan_act  = '0;
    for (int i = 0; i < REC_CHANS; i++)  // RULE_13
    begin
      idx = chan_sel[i] - REC_BIT0;
      if (chan_sel[i] == REC_ANALOG)
      begin
        chan_act[i] = !ana_taken;
        ana_taken   = 1'b1;
      end
      else if (chan_sel[i] >= REC_BIT0 && idx < 6'(REC_BITS))
      begin
        chan_act[i] = 1'b1;
        chan_bit[i] = bit_pool[idx];
      end
    end
  end

endmodule

/* adg_status_top.sv */
// What this block does
// RULE_01: Config-valid bit is 1 while configuration valid, else 0.
// RULE_02: Per sensor, lower input range bit clears below 3.5 mA.
// RULE_03: Per sensor, upper input range bit clears above 20.5 mA.
// RULE_04: Per sensor, lower process bit clears below process range minimum.
// RULE_05: Per sensor, upper process bit clears above process range maximum.
// RULE_06: Discrepancy bit reads 1 without discrepancy, 0 on discrepancy error.
// RULE_07: Consolidated value has lower and upper process range bits.
// RULE_08: Measured value is unsigned 16 bits, bit 0 least significant.
// RULE_09: Consumer converts value times gradient, divided by 2500, plus offset.
// RULE_10: Consumer always uses first sensor gradient and offset.
// RULE_11: Input data status is 1 only with valid sensors, no discrepancy.
// RULE_12: One recordable analog value chosen from six sources.
// RULE_13: Recorder also takes bits; at most four channels total.
// RULE_14: Status bits refresh about every 200 ms.
// RULE_15: Hide option forces measured value bits 16 to 31 to ones.
// RULE_16: All status bits and value captured together in one cycle.
module adg_status_top
  import adg_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES = REFRESH_CYC
)
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        cfg_valid,
  input  wire logic        disc_err,
  input  wire logic        hide_mv,
  input  wire logic [15:0] first_sensor_input_ua,
  input  wire logic [15:0] second_sensor_input_ua,
  input  wire logic [15:0] first_sensor_input_filt,
  input  wire logic [15:0] second_sensor_input_filt,
  input  wire logic [15:0] first_sensor_input_raw,
  input  wire logic [15:0] second_sensor_input_raw,
  input  wire logic [15:0] first_sensor_input_delay,
  input  wire logic [15:0] cons_val,
  input  wire logic [15:0] proc_min,
  input  wire logic [15:0] proc_max,
  input  wire logic [6:0]  sig_range,
  input  wire logic [3:0]  proc_range_sel,
  input  wire adg_src_e    rec_src,
  input  wire logic [5:0]  rec_chan_sel [REC_CHANS],
  output logic [31:0]      status_word,
  output logic             status_tick,
  output logic             sensor_status,
  output logic             enable_out,
  output logic [15:0]      rec_ana,
  output logic [REC_CHANS-1:0] rec_bit,
  output logic [REC_CHANS-1:0] rec_act
);

  // ----------------------------------------------------------------
  // Range checks
  // ----------------------------------------------------------------
  adg_meas_if meas ();

  assign meas.cur_ua[0] = first_sensor_input_ua;
  assign meas.cur_ua[1] = second_sensor_input_ua;
  assign meas.filt[0]   = first_sensor_input_filt;
  assign meas.filt[1]   = second_sensor_input_filt;
  assign meas.raw[0]    = first_sensor_input_raw;
  assign meas.raw[1]    = second_sensor_input_raw;
  assign meas.s1_delay  = first_sensor_input_delay;
  assign meas.cons_val  = cons_val;
  assign meas.proc_min  = proc_min;
  assign meas.proc_max  = proc_max;

  adg_range_chk u_chk (
    .m (meas.chk)
  );

  // ----------------------------------------------------------------
  // Live flags
  // ----------------------------------------------------------------
  logic        sens_ok;
  logic        enab_ok;
  logic [31:0] live_word;

  // Sensor valid means both loop currents inside the input range and no discrepancy error
  assign sens_ok = (&meas.lo_in_ok) & (&meas.hi_in_ok) & !disc_err;  // RULE_11
  assign enab_ok = sens_ok & meas.cn_lo_ok & meas.cn_hi_ok;

  always_comb
  begin
    live_word              = '0;
    live_word[SB_CFG_OK]   = cfg_valid;  // RULE_01
    live_word[SB_S1_LO_IN] = meas.lo_in_ok[0];  // RULE_02
    live_word[SB_S1_HI_IN] = meas.hi_in_ok[0];  // RULE_03
    live_word[SB_S2_LO_IN] = meas.lo_in_ok[1];  // RULE_02
    live_word[SB_S2_HI_IN] = meas.hi_in_ok[1];  // RULE_03
    live_word[SB_S1_LO_PR] = meas.lo_pr_ok[0];  // RULE_04
    live_word[SB_S1_HI_PR] = meas.hi_pr_ok[0];  // RULE_05
    live_word[SB_S2_LO_PR] = meas.lo_pr_ok[1];  // RULE_04
    live_word[SB_S2_HI_PR] = meas.hi_pr_ok[1];  // RULE_05
    live_word[SB_DISC_OK]  = !disc_err;  // RULE_06
    live_word[SB_CN_LO_PR] = meas.cn_lo_ok;  // RULE_07
    live_word[SB_CN_HI_PR] = meas.cn_hi_ok;  // RULE_07
    live_word[SB_IN_DATA]  = sens_ok;  // RULE_11
    // Hidden value stays static so a gateway sees no toggling bits
    if (hide_mv)
      live_word[SB_MV_MSB:SB_MV_LSB] = MV_HIDDEN;  // RULE_15
    else
      live_word[SB_MV_MSB:SB_MV_LSB] = cons_val;  // RULE_08
  end

  // ----------------------------------------------------------------
  // Refresh timer and snapshot
  // ----------------------------------------------------------------
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic        tick_ff;
  logic        nxt_tick;
  logic [31:0] word_ff;
  logic [31:0] nxt_word;

  // Status lags process data by up to one refresh period
  always_comb
  begin
    nxt_tick = 1'b0;
    nxt_cnt  = cnt_ff + 32'h0000_0001;
    nxt_word = word_ff;
    if (cnt_ff >= 32'(REFRESH_CYCLES - 1))  // RULE_14
    begin
      nxt_cnt  = '0;
      nxt_tick = 1'b1;
      nxt_word = live_word;  // RULE_16
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
      word_ff <= STATUS_RST;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
      word_ff <= nxt_word;
    end
  end

  assign status_word = word_ff;
  assign status_tick = tick_ff;

  // ----------------------------------------------------------------
  // Logic-editor flags, per processing cycle
  // ----------------------------------------------------------------
  logic sens_ff;
  logic nxt_sens;
  logic enab_ff;
  logic nxt_enab;

  always_comb
  begin
    nxt_sens = sens_ok;  // RULE_11
    nxt_enab = enab_ok;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sens_ff <= 1'b0;
      enab_ff <= 1'b0;
    end
    else
    begin
      sens_ff <= nxt_sens;
      enab_ff <= nxt_enab;
    end
  end

  assign sensor_status = sens_ff;
  assign enable_out    = enab_ff;

  // ----------------------------------------------------------------
  // Data recorder
  // ----------------------------------------------------------------
  logic [REC_BITS-1:0]  pool;
  logic [15:0]          ana_c;
  logic [REC_CHANS-1:0] bit_c;
  logic [REC_CHANS-1:0] act_c;

  // Recorded status word bits come from the slow snapshot; the sensor and enable flags are live
  assign pool = {proc_range_sel, sens_ok, enab_ok, sig_range, word_ff};

  adg_rec_sel u_rec (
    .m        (meas.rec),
    .ana_src  (rec_src),
    .chan_sel (rec_chan_sel),
    .bit_pool (pool),
    .ana_val  (ana_c),
    .chan_bit (bit_c),
    .chan_act (act_c)
  );

  logic [15:0]          ana_ff;
  logic [15:0]          nxt_ana;
  logic [REC_CHANS-1:0] rbit_ff;
  logic [REC_CHANS-1:0] nxt_rbit;
  logic [REC_CHANS-1:0] ract_ff;
  logic [REC_CHANS-1:0] nxt_ract;

  always_comb
  begin
    nxt_ana  = ana_c;  // RULE_12
    nxt_rbit = bit_c;  // RULE_13
    nxt_ract = act_c;  // RULE_13
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ana_ff  <= '0;
      rbit_ff <= '0;
      ract_ff <= '0;
    end
    else
    begin
      ana_ff  <= nxt_ana;
      rbit_ff <= nxt_rbit;
      ract_ff <= nxt_ract;
    end
  end

  assign rec_ana = ana_ff;
  assign rec_bit = rbit_ff;
  assign rec_act = ract_ff;

endmodule

/* adg_status_assertions.sv */
module adg_status_assertions
  import adg_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES = 8
)
(
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        cfg_valid,
  input wire logic        disc_err,
  input wire logic        hide_mv,
  input wire logic [15:0] first_sensor_input_ua,
  input wire logic [15:0] second_sensor_input_ua,
  input wire logic [15:0] first_sensor_input_filt,
  input wire logic [15:0] second_sensor_input_filt,
  input wire logic [15:0] cons_val,
  input wire logic [15:0] proc_min,
  input wire logic [15:0] proc_max,
  input wire logic [31:0] status_word,
  input wire logic        status_tick,
  input wire logic        sensor_status
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Live status from inputs; compared one edge later
  // ----------------------------------------------------------------
  logic [12:0] live;
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic        seen_ff;
  logic        nxt_seen;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  always_comb
  begin
    live[0]  = cfg_valid;
    live[1]  = first_sensor_input_ua >= CUR_LO_UA;
    live[2]  = first_sensor_input_ua <= CUR_HI_UA;
    live[3]  = second_sensor_input_ua >= CUR_LO_UA;
    live[4]  = second_sensor_input_ua <= CUR_HI_UA;
    live[5]  = first_sensor_input_filt >= proc_min;
    live[6]  = first_sensor_input_filt <= proc_max;
    live[7]  = second_sensor_input_filt >= proc_min;
    live[8]  = second_sensor_input_filt <= proc_max;
    live[9]  = !disc_err;
    live[10] = cons_val >= proc_min;
    live[11] = cons_val <= proc_max;
    live[12] = (&live[4:1]) & !disc_err;
    nxt_cnt  = status_tick ? 32'h0 : cnt_ff + 32'h1;
    nxt_seen = seen_ff | status_tick;
  end
  // Period checked only after the first tick, so release timing is not judged
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      cnt_ff  <= 32'h0;
      seen_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      seen_ff <= nxt_seen;
    end
  sequence s_pulse;
    status_tick ##1 !status_tick;
  endsequence
  a_cfg_bit: assert property (status_tick |-> status_word[0] == $past(live[0]))
    else $error("config bit wrong");
  a_lo_input: assert property (status_tick |->
    {status_word[3], status_word[1]} == $past({live[3], live[1]}))
    else $error("lower input bit wrong");
  a_hi_input: assert property (status_tick |-> {status_word[4], status_word[2]} == $past({live[4], live[2]}))
    else $error("upper input bit wrong");
  a_lo_proc: assert property (status_tick |-> {status_word[7], status_word[5]} == $past({live[7], live[5]}))
    else $error("lower process bit wrong");
  a_hi_proc: assert property (status_tick |-> {status_word[8], status_word[6]} == $past({live[8], live[6]}))
    else $error("upper process bit wrong");
  a_disc_bit: assert property (status_tick |-> status_word[9] == $past(live[9]))
    else $error("discrepancy bit wrong");
  a_cons_range: assert property (status_tick |-> status_word[11:10] == $past(live[11:10]))
    else $error("consolidated range bits wrong");
  a_value_field: assert property (status_tick |-> status_word[31:16] == ($past(hide_mv) ? MV_HIDDEN : $past(cons_val)))
    else $error("measured value field wrong");
  a_data_status: assert property ($past(rstn) |-> sensor_status == $past(live[12]))
    else $error("sensor status wrong");
  a_tick_period: assert property (seen_ff |-> status_tick == (cnt_ff == REFRESH_CYCLES - 1))
    else $error("refresh period wrong");
  a_word_held: assert property (!status_tick |-> $stable(status_word))
    else $error("status word changed off tick");
  a_tick_pulse: assert property (status_tick |-> s_pulse)
    else $error("tick longer than one cycle");
endmodule

bind adg_status_top adg_status_assertions #(.REFRESH_CYCLES(REFRESH_CYCLES)) i_chk (
  .mclk, .rstn, .cfg_valid, .disc_err, .hide_mv, .first_sensor_input_ua,
  .second_sensor_input_ua, .first_sensor_input_filt, .second_sensor_input_filt,
  .cons_val, .proc_min, .proc_max, .status_word, .status_tick, .sensor_status
);

/* adg_reader.sv */
module adg_reader
#(
  parameter int GRAD = 100,
  parameter int OFFS = 4
)
(
  input  wire logic        mclk,
  input  wire logic [31:0] status_word,
  input  wire logic        status_tick,
  output int               eng_val
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Controller side: reads the word only on a fresh snapshot
  // ----------------------------------------------------------------
  // First sensor scaling always, whatever the merge mode
  always @(posedge mclk)
    if (status_tick === 1'b1)
      eng_val <= int'(status_word[31:16]) * GRAD / 2500 + OFFS;
endmodule

/* testbench.sv */
module testbench;
  import adg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned R = 8;
  localparam int GR = 100;
  localparam int OF = 4;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        cfg_valid, disc_err, hide_mv, status_tick, sensor_status, enable_out;
  logic [15:0] first_sensor_input_ua, second_sensor_input_ua, first_sensor_input_filt;
  logic [15:0] second_sensor_input_filt, first_sensor_input_raw, second_sensor_input_raw;
  logic [15:0] first_sensor_input_delay, cons_val, proc_min, proc_max, rec_ana, ea;
  logic [6:0]  sig_range;
  logic [3:0]  proc_range_sel, rec_bit, rec_act, eact;
  adg_src_e    rec_src;
  logic [5:0]  rec_chan_sel [REC_CHANS];
  logic [31:0] status_word, ew;
  logic        es, ee, ana_on;
  logic [31:0] mw;
  logic [REC_BITS-1:0] ep;
  logic [3:0]  eb;
  int          pend, pev;
  int          armed, gap, eng;
  int          errors = 0;
  int          checks_done = 0;

  always #5 mclk = ~mclk;

  adg_status_top #(.REFRESH_CYCLES(R)) i_dut (
    .mclk, .rstn, .cfg_valid, .disc_err, .hide_mv, .first_sensor_input_ua,
    .second_sensor_input_ua, .first_sensor_input_filt, .second_sensor_input_filt,
    .first_sensor_input_raw, .second_sensor_input_raw, .first_sensor_input_delay,
    .cons_val, .proc_min, .proc_max, .sig_range, .proc_range_sel, .rec_src,
    .rec_chan_sel, .status_word, .status_tick, .sensor_status, .enable_out,
    .rec_ana, .rec_bit, .rec_act
  );
  adg_reader #(.GRAD(GR), .OFFS(OF)) i_reader (.mclk, .status_word, .status_tick, .eng_val(eng));

  // ----------------------------------------------------------------
  // Reference model and checks
  // ----------------------------------------------------------------
  function automatic logic [15:0] near(logic [15:0] a, logic [15:0] b);
    logic [15:0] v [5];
    v = '{a - 16'h1, a, b, b + 16'h1, 16'($urandom_range(a, b))};
    return v[$urandom_range(0, 4)];
  endfunction

  function automatic logic [31:0] word_of();
    logic [12:0] b;
    logic [15:0] u [2];
    logic [15:0] f [2];
    u = '{first_sensor_input_ua, second_sensor_input_ua};
    f = '{first_sensor_input_filt, second_sensor_input_filt};
    b[0] = cfg_valid;
    for (int i = 0; i < 2; i++)
    begin
      b[1 + 2 * i] = u[i] >= CUR_LO_UA;
      b[2 + 2 * i] = u[i] <= CUR_HI_UA;
      b[5 + 2 * i] = f[i] >= proc_min;
      b[6 + 2 * i] = f[i] <= proc_max;
    end
    b[9]  = !disc_err;
    b[10] = cons_val >= proc_min;
    b[11] = cons_val <= proc_max;
    b[12] = (&b[4:1]) & b[9];
    return {hide_mv ? MV_HIDDEN : cons_val, 3'h0, b};
  endfunction

  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checks_done++;
    if (e !== s)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  always @(posedge mclk)
  begin
    logic [15:0] v [6];
    logic        a;
    v = '{first_sensor_input_filt, second_sensor_input_filt, first_sensor_input_delay,
          cons_val, first_sensor_input_raw, second_sensor_input_raw};
    armed = rstn ? armed + 1 : 0;
    ew = word_of();
    es = ew[12];
    ee = es & ew[10] & ew[11];
    ep = {proc_range_sel, es, ee, sig_range, mw};
    ea = v[rec_src];
    ana_on = rec_chan_sel[0] == REC_ANALOG;
    a = 1'b0;
    // Only the first analog channel wins; later ones stay idle
    for (int i = 0; i < REC_CHANS; i++)
    begin
      eact[i] = rec_chan_sel[i] == REC_ANALOG ? !a :
                rec_chan_sel[i] >= REC_BIT0 && rec_chan_sel[i] < 6'h2f;
      a |= rec_chan_sel[i] == REC_ANALOG;
      eb[i] = rec_chan_sel[i] >= REC_BIT0 && rec_chan_sel[i] < 6'h2f ?
              ep[rec_chan_sel[i] - REC_BIT0] : 1'b0;
    end
    // Model snapshot follows its own count, not the design's tick
    if (!rstn)
      mw = STATUS_RST;
    else if (armed % R == 0)
      mw = ew;
  end

  always @(negedge mclk)
    if (armed >= 2)
    begin
      gap = status_tick === 1'b1 ? 0 : gap + 1;
      if (status_tick === 1'b1) chk("status_word", ew, status_word);
      if (gap >= R) chk("tick gap", R - 1, gap);
      chk("sensor_status", es, sensor_status);
      chk("enable_out", ee, enable_out);
      chk("rec_act", eact, rec_act);
      if (ana_on) chk("rec_ana", ea, rec_ana);
      chk("status_tick", armed % R == 0, status_tick);
      chk("status_word hold", mw, status_word);
      chk("rec_bit", eb, rec_bit);
      if (pend) chk("eng_val", pev, eng);
      pend = status_tick === 1'b1;
      pev = int'(ew[31:16]) * GR / 2500 + OF;
    end
    else
    begin
      gap = 0;
      pend = 0;
    end

  task automatic drive();
    cfg_valid = 1'($urandom_range(0, 1));
    disc_err = 1'($urandom_range(0, 1));
    hide_mv = 1'($urandom_range(0, 1));
    proc_min = 16'($urandom_range(1, 500));
    proc_max = proc_min + 16'($urandom_range(0, 500));
    first_sensor_input_ua = near(CUR_LO_UA, CUR_HI_UA);
    second_sensor_input_ua = near(CUR_LO_UA, CUR_HI_UA);
    first_sensor_input_filt = near(proc_min, proc_max);
    second_sensor_input_filt = near(proc_min, proc_max);
    cons_val = near(proc_min, proc_max);
    first_sensor_input_raw = 16'($urandom);
    second_sensor_input_raw = 16'($urandom);
    first_sensor_input_delay = 16'($urandom);
    sig_range = 7'($urandom);
    proc_range_sel = 4'($urandom);
    rec_src = adg_src_e'($urandom_range(0, 5));
  endtask

  task automatic run(int n, bit all_analog);
    repeat (n)
    begin
      @(negedge mclk);
      drive();
      for (int i = 0; i < REC_CHANS; i++)
        rec_chan_sel[i] = all_analog ? REC_ANALOG : 6'($urandom_range(0, 48));
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    void'($urandom(31401));
    rec_chan_sel = '{default: REC_OFF};
    drive();
    repeat (4) @(negedge mclk);
    rstn = 1'b1;
    run(400, 1'b0);
    $display("test random status done");
    run(40, 1'b1);
    $display("test all analog done");
    rstn = 1'b0;
    repeat (2) @(negedge mclk);
    chk("reset word", 32'h0, status_word);
    rstn = 1'b1;
    run(60, 1'b0);
    $display("test mid reset done");
    conclude();
  end

  // Run needs about 506 cycles
  initial
  begin
    #20000;
    errors++;
    conclude();
  end
endmodule
